// *** src/adcocr_pkg.sv ***
// constants, register map and carrier types for the adc output configuration bank
// Behaviour
// - add signed six-bit offset trim (+31..-32 lsb, default 0) to every result
// - format field: 00 offset binary, 01 twos complement default, 10 gray, 11 reserved
// - output port driven while active-low enable bit is clear; off when set
// - conversion output data inverted when invert bit is one, normal when zero; test word never inverted
// - with delay enabled, data clock delayed 100 ps plus 100 ps per code step
// - selected test mode puts test word, e.g. user pattern, on outputs
package adcocr_pkg;

    localparam logic [7:0] ADDR_SELF_TEST  = 8'h0e;
    localparam logic [7:0] ADDR_OFFSET     = 8'h10;
    localparam logic [7:0] ADDR_FORMAT     = 8'h14;
    localparam logic [7:0] ADDR_DRIVE      = 8'h15;
    localparam logic [7:0] ADDR_CLK_POL    = 8'h16;
    localparam logic [7:0] ADDR_CLK_DELAY  = 8'h17;
    localparam logic [7:0] ADDR_RANGE      = 8'h18;
    localparam logic [7:0] ADDR_PAT1_LO    = 8'h19;
    localparam logic [7:0] ADDR_PAT1_HI    = 8'h1a;

    // writable bits; open bits read back as zero
    localparam logic [7:0] MASK_SELF_TEST  = 8'h05;
    localparam logic [7:0] MASK_OFFSET     = 8'h3f;
    localparam logic [7:0] MASK_FORMAT     = 8'h17;
    localparam logic [7:0] MASK_DRIVE      = 8'h0f;
    localparam logic [7:0] MASK_CLK_POL    = 8'h80;
    localparam logic [7:0] MASK_CLK_DELAY  = 8'h9f;
    localparam logic [7:0] MASK_RANGE      = 8'h1f;
    localparam logic [7:0] MASK_FULL       = 8'hff;

    localparam logic [7:0] RST_SELF_TEST   = 8'h00;
    localparam logic [7:0] RST_OFFSET      = 8'h00;
    localparam logic [7:0] RST_FORMAT      = 8'h01;
    localparam logic [7:0] RST_DRIVE       = 8'h01;
    localparam logic [7:0] RST_CLK_POL     = 8'h00;
    localparam logic [7:0] RST_CLK_DELAY   = 8'h00;
    localparam logic [7:0] RST_RANGE       = 8'h00;
    localparam logic [7:0] RST_PATTERN     = 8'h00;

    // field positions
    localparam int BIT_ST_ENABLE   = 0;
    localparam int BIT_ST_RESTART  = 2;
    localparam int BIT_OE_BAR      = 4;
    localparam int BIT_INVERT      = 2;
    localparam int BIT_CLK_INVERT  = 7;
    localparam int BIT_DLY_ENABLE  = 7;

    localparam int SAMPLE_W        = 14;
    localparam int OFFSET_W        = 6;
    localparam int DLY_CODE_W      = 5;

    // base delay and delay step of the analog output clock line
    localparam int DLY_BASE_PS     = 100;
    localparam int DLY_STEP_PS     = 100;

    localparam logic [SAMPLE_W-1:0] SAT_POS = 14'h1fff;
    localparam logic [SAMPLE_W-1:0] SAT_NEG = 14'h2000;

    typedef enum logic [1:0] {
        ADCOCR_FMT_OFFSET_BIN = 2'h0,
        ADCOCR_FMT_TWOS       = 2'h1,
        ADCOCR_FMT_GRAY       = 2'h2,
        ADCOCR_FMT_RESERVED   = 2'h3
    } adcocr_fmt_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } adcocr_reg_req_t;

    typedef struct packed {
        logic       invert;
        logic       delay_en;
        logic [4:0] delay_code;
    } adcocr_clk_cfg_t;

    typedef struct packed {
        logic [7:0]          self_test;
        logic [7:0]          offset;
        logic [7:0]          format;
        logic [7:0]          drive;
        logic [7:0]          clk_pol;
        logic [7:0]          clk_delay;
        logic [7:0]          range;
        logic [7:0]          pat_lo;
        logic [7:0]          pat_hi;
        logic [7:0]          rdata;
        logic                rvalid;
        logic [SAMPLE_W-1:0] dout;
        logic                dvalid;
        logic                oe;
        logic                restart;
    } adcocr_state_t;

endpackage : adcocr_pkg

// *** src/adcocr_regs.sv ***
// output configuration registers and output data path of the adc
`timescale 1ns/1ns
module adcocr_regs
    import adcocr_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                nrst,
    input  wire adcocr_reg_req_t     reg_req,
    output logic [7:0]               reg_rdata,
    output logic                     reg_rvalid,
    input  wire logic [SAMPLE_W-1:0] conv_data,
    input  wire logic                conv_valid,
    input  wire logic                test_sel,
    output logic [SAMPLE_W-1:0]      out_data,
    output logic                     out_valid,
    output logic                     out_oe,
    output adcocr_clk_cfg_t          out_clk_cfg,
    output logic [3:0]               drive_strength,
    output logic [4:0]               range_select,
    output logic                     self_check_run,
    output logic                     self_check_restart
);

    adcocr_state_t s_r;
    adcocr_state_t s_nxt;

    logic [SAMPLE_W:0]   sum;
    logic [SAMPLE_W-1:0] sat;
    logic [SAMPLE_W-1:0] obin;
    logic [SAMPLE_W-1:0] coded;
    logic [SAMPLE_W-1:0] pattern;

    function automatic logic [7:0] wr_field(input logic [7:0] old,
                                            input logic [7:0] val,
                                            input logic [7:0] mask);
        wr_field = (old & ~mask) | (val & mask);
    endfunction

    always_comb begin
        s_nxt = s_r;
        // sign-extend both operands one bit so the sum cannot wrap
        sum = {conv_data[SAMPLE_W-1], conv_data}
            + {{(SAMPLE_W+1-OFFSET_W){s_r.offset[OFFSET_W-1]}}, s_r.offset[OFFSET_W-1:0]};
        if (sum[SAMPLE_W] != sum[SAMPLE_W-1]) begin
            sat = sum[SAMPLE_W] ? SAT_NEG : SAT_POS;
        end else begin
            sat = sum[SAMPLE_W-1:0];
        end
        obin = {~sat[SAMPLE_W-1], sat[SAMPLE_W-2:0]};
        case (adcocr_fmt_t'(s_r.format[1:0]))
            ADCOCR_FMT_OFFSET_BIN: coded = obin;
            ADCOCR_FMT_TWOS:       coded = sat;
            ADCOCR_FMT_GRAY:       coded = obin ^ (obin >> 1);
            // reserved code: hold twos complement rather than emit garbage
            default:               coded = sat;
        endcase
        if (s_r.format[BIT_INVERT]) begin
            coded = ~coded;
        end
        // the pattern word is msb-justified onto the 14 output bits
        pattern = {s_r.pat_hi, s_r.pat_lo[7:2]};

        s_nxt.dvalid = conv_valid | test_sel;
        if (test_sel) begin
            s_nxt.dout = pattern;
        end else if (conv_valid) begin
            s_nxt.dout = coded;
        end
        s_nxt.oe      = ~s_r.format[BIT_OE_BAR];
        // pulse, not level: the stored restart bit must not retrigger on later writes
        s_nxt.restart = 1'b0;
        s_nxt.rvalid  = reg_req.re;

        if (reg_req.we) begin
            case (reg_req.addr)
                ADDR_SELF_TEST: begin
                    s_nxt.self_test = wr_field(s_r.self_test, reg_req.wdata, MASK_SELF_TEST);
                    s_nxt.restart   = reg_req.wdata[BIT_ST_RESTART];
                end
                ADDR_OFFSET:    s_nxt.offset    = wr_field(s_r.offset, reg_req.wdata, MASK_OFFSET);
                ADDR_FORMAT:    s_nxt.format    = wr_field(s_r.format, reg_req.wdata, MASK_FORMAT);
                ADDR_DRIVE:     s_nxt.drive     = wr_field(s_r.drive, reg_req.wdata, MASK_DRIVE);
                ADDR_CLK_POL:   s_nxt.clk_pol   = wr_field(s_r.clk_pol, reg_req.wdata, MASK_CLK_POL);
                ADDR_CLK_DELAY: s_nxt.clk_delay = wr_field(s_r.clk_delay, reg_req.wdata,
                                                           MASK_CLK_DELAY);
                ADDR_RANGE:     s_nxt.range     = wr_field(s_r.range, reg_req.wdata, MASK_RANGE);
                ADDR_PAT1_LO:   s_nxt.pat_lo    = reg_req.wdata;
                ADDR_PAT1_HI:   s_nxt.pat_hi    = reg_req.wdata;
                // unmapped addresses: the write is dropped
                default: ;
            endcase
        end

        if (reg_req.re) begin
            case (reg_req.addr)
                ADDR_SELF_TEST: s_nxt.rdata = s_r.self_test;
                ADDR_OFFSET:    s_nxt.rdata = s_r.offset;
                ADDR_FORMAT:    s_nxt.rdata = s_r.format;
                ADDR_DRIVE:     s_nxt.rdata = s_r.drive;
                ADDR_CLK_POL:   s_nxt.rdata = s_r.clk_pol;
                ADDR_CLK_DELAY: s_nxt.rdata = s_r.clk_delay;
                ADDR_RANGE:     s_nxt.rdata = s_r.range;
                ADDR_PAT1_LO:   s_nxt.rdata = s_r.pat_lo;
                ADDR_PAT1_HI:   s_nxt.rdata = s_r.pat_hi;
                default:        s_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            // clear all, then load defaults; the output port comes up driving
            s_r           <= '0;
            s_r.self_test <= RST_SELF_TEST;
            s_r.offset    <= RST_OFFSET;
            s_r.format    <= RST_FORMAT;
            s_r.drive     <= RST_DRIVE;
            s_r.clk_pol   <= RST_CLK_POL;
            s_r.clk_delay <= RST_CLK_DELAY;
            s_r.range     <= RST_RANGE;
            s_r.pat_lo    <= RST_PATTERN;
            s_r.pat_hi    <= RST_PATTERN;
            s_r.oe        <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata              = s_r.rdata;
    assign reg_rvalid             = s_r.rvalid;
    assign out_data               = s_r.dout;
    assign out_valid              = s_r.dvalid;
    assign out_oe                 = s_r.oe;
    assign out_clk_cfg.invert     = s_r.clk_pol[BIT_CLK_INVERT];
    // analog line delays by DLY_BASE_PS + DLY_STEP_PS * code when enabled
    assign out_clk_cfg.delay_en   = s_r.clk_delay[BIT_DLY_ENABLE];
    assign out_clk_cfg.delay_code = s_r.clk_delay[DLY_CODE_W-1:0];
    assign drive_strength         = s_r.drive[3:0];
    assign range_select           = s_r.range[4:0];
    assign self_check_run         = s_r.self_test[BIT_ST_ENABLE];
    assign self_check_restart     = s_r.restart;

    // checks
    offset_add_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(conv_valid) && !$past(test_sel) && $past(s_r.format) == 8'h01
        && $past(conv_data) == 14'h0000
        |-> out_data == {{(SAMPLE_W-OFFSET_W){$past(s_r.offset[5])}}, $past(s_r.offset[5:0])})
        else $error("offset not added to sample");

    offset_sat_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(conv_valid) && !$past(test_sel) && $past(s_r.format) == 8'h01
        && $past(conv_data) == 14'h1fff && $past(s_r.offset[5]) == 1'b0
        |-> out_data == 14'h1fff)
        else $error("positive saturation missed");

    fmt_obin_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(conv_valid) && !$past(test_sel) && $past(s_r.format) == 8'h00
        && $past(s_r.offset[5:0]) == 6'h00
        |-> out_data == {~$past(conv_data[13]), $past(conv_data[12:0])})
        else $error("offset binary coding wrong");

    fmt_gray_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(conv_valid) && !$past(test_sel) && $past(s_r.format) == 8'h02
        |-> out_data[13] == ~$past(sat[13])
            && out_data[12] == ($past(sat[12]) ^ ~$past(sat[13])))
        else $error("gray coding wrong");

    oe_follow_a: assert property (@(posedge core_clk) disable iff (!nrst)
        ##1 out_oe == !$past(s_r.format[BIT_OE_BAR]))
        else $error("output enable does not follow control");

    output_invert_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(conv_valid) && !$past(test_sel) && $past(s_r.format) == 8'h05
        |-> out_data == ~$past(sat))
        else $error("output not inverted");

    delay_cfg_a: assert property (@(posedge core_clk) disable iff (!nrst)
        reg_req.we && reg_req.addr == ADDR_CLK_DELAY
        |=> out_clk_cfg.delay_en == $past(reg_req.wdata[7])
            && out_clk_cfg.delay_code == $past(reg_req.wdata[4:0]))
        else $error("clock delay setting not applied");

    test_word_a: assert property (@(posedge core_clk) disable iff (!nrst)
        test_sel |=> out_valid && out_data == $past(pattern))
        else $error("test word not on outputs");

    restart_pulse_a: assert property (@(posedge core_clk) disable iff (!nrst)
        reg_req.we && reg_req.addr == ADDR_SELF_TEST && reg_req.wdata[2]
        |=> self_check_restart && self_check_run == $past(reg_req.wdata[0])
            ##1 (!self_check_restart
                 || $past(reg_req.we && reg_req.addr == ADDR_SELF_TEST && reg_req.wdata[2])))
        else $error("self-check restart pulse wrong");

    restart_only_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !(reg_req.we && reg_req.addr == ADDR_SELF_TEST && reg_req.wdata[BIT_ST_RESTART])
        |=> !self_check_restart)
        else $error("self-check restart without request");

    run_level_a: assert property (@(posedge core_clk) disable iff (!nrst)
        reg_req.we && reg_req.addr == ADDR_SELF_TEST
        |=> self_check_run == $past(reg_req.wdata[BIT_ST_ENABLE]))
        else $error("self-check enable not applied");

    valid_follow_a: assert property (@(posedge core_clk) disable iff (!nrst)
        ##1 out_valid == $past(conv_valid || test_sel))
        else $error("output valid does not follow strobes");

    delay_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !(reg_req.we && reg_req.addr == ADDR_CLK_DELAY)
        |=> $stable({out_clk_cfg.delay_en, out_clk_cfg.delay_code}))
        else $error("clock delay setting changed without write");

    fmt_twos_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(conv_valid) && !$past(test_sel) && $past(s_r.format) == 8'h01
        && $past(s_r.offset[5:0]) == 6'h00
        |-> out_data == $past(conv_data))
        else $error("twos complement coding wrong");

    offset_neg_sat_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(conv_valid) && !$past(test_sel) && $past(s_r.format) == 8'h01
        && $past(conv_data) == 14'h2000 && $past(s_r.offset[5]) == 1'b1
        |-> out_data == 14'h2000)
        else $error("negative saturation missed");

endmodule // adcocr_regs

// *** dv/adcocr_host.sv ***
// host controller model driving the register port of the output configuration bank
`timescale 1ns/1ns
module adcocr_host
    import adcocr_pkg::*;
(
    input  wire logic       core_clk,
    output adcocr_reg_req_t reg_req,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    initial reg_req = '0;
    // released lines carry the inverse so a stale address never looks held
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge core_clk);
        reg_req <= '{addr: ~a, wdata: ~d, we: 1'b0, re: 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge core_clk);
        reg_req <= '{addr: ~a, wdata: 8'hff, we: 1'b0, re: 1'b0};
        #1;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    endtask
endmodule // adcocr_host

// *** dv/adcocr_regs_tb.sv ***
// self-checking bench for the adc output configuration bank
`timescale 1ns/1ns
module adcocr_regs_tb
    import adcocr_pkg::*;
;
    logic               core_clk = 1'b0;
    logic               nrst = 1'b0;
    adcocr_reg_req_t    reg_req;
    logic [7:0]         reg_rdata;
    logic               reg_rvalid;
    logic [13:0]        conv_data = 14'h0000;
    logic               conv_valid = 1'b0;
    logic               test_sel = 1'b0;
    logic [13:0]        out_data;
    logic               out_valid;
    logic               out_oe;
    adcocr_clk_cfg_t    out_clk_cfg;
    int                 mismatches = 0;
    int                 cmp_count = 0;
    int                 pulses = 0;

    logic               self_check_restart;
    logic               self_check_run;
    logic [3:0]         drive_strength;
    logic [4:0]         range_select;

    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) if (self_check_restart === 1'b1) pulses++;

    adcocr_regs adcocr_regs_i (.core_clk(core_clk), .nrst(nrst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .conv_data(conv_data),
        .conv_valid(conv_valid), .test_sel(test_sel), .out_data(out_data),
        .out_valid(out_valid), .out_oe(out_oe), .out_clk_cfg(out_clk_cfg),
        .drive_strength(drive_strength), .range_select(range_select),
        .self_check_run(self_check_run), .self_check_restart(self_check_restart));

    adcocr_host adcocr_host_i (.core_clk(core_clk), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        adcocr_host_i.rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask
    task automatic smp(input logic [13:0] d, input logic [13:0] exp);
        @(posedge core_clk);
        conv_valid <= 1'b1;
        conv_data  <= d;
        @(posedge core_clk);
        conv_valid <= 1'b0;
        conv_data  <= ~d;
        #1;
        chk({1'b0, out_valid, out_data}, {2'b01, exp});
    endtask

    task automatic t_reset();
        logic [7:0] ad [10] = '{8'h0e, 8'h10, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
                                8'h19, 8'h1a, 8'h11};
        logic [7:0] ex [10] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00,
                                8'h00, 8'h00, 8'h00};
        #1;
        chk({8'h00, out_oe, out_clk_cfg}, 16'h0080);
        chk({7'h00, drive_strength, range_select}, 16'h0020);
        for (int i = 0; i < 10; i++) rchk(ad[i], ex[i]);
        $display("test reset done");
    endtask
    task automatic t_offset();
        adcocr_host_i.wr(8'h10, 8'h05);
        smp(14'h0000, 14'h0005);
        adcocr_host_i.wr(8'h10, 8'h3f);
        smp(14'h0000, 14'h3fff);
        adcocr_host_i.wr(8'h10, 8'h1f);
        smp(14'h1ff0, 14'h1fff);
        smp(14'h1fff, 14'h1fff);
        adcocr_host_i.wr(8'h10, 8'h20);
        smp(14'h2000, 14'h2000);
        smp(14'h0000, 14'h3fe0);
        adcocr_host_i.wr(8'h10, 8'h00);
        $display("test offset done");
    endtask
    task automatic t_format();
        logic [7:0]  md [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05};
        logic [13:0] ex [5] = '{14'h2123, 14'h0123, 14'h31b2, 14'h0123, 14'h3edc};
        for (int i = 0; i < 5; i++) begin
            adcocr_host_i.wr(8'h14, md[i]);
            smp(14'h0123, ex[i]);
        end
        adcocr_host_i.wr(8'h14, 8'hff);
        rchk(8'h14, 8'h17);
        adcocr_host_i.wr(8'h14, 8'h01);
        $display("test format done");
    endtask
    task automatic t_oe_clk();
        adcocr_host_i.wr(8'h14, 8'h11);
        adcocr_host_i.wr(8'h17, 8'h9f);
        adcocr_host_i.wr(8'h16, 8'h80);
        @(posedge core_clk);
        #1;
        chk({8'h00, out_oe, out_clk_cfg}, 16'h007f);
        rchk(8'h17, 8'h9f);
        adcocr_host_i.wr(8'h14, 8'h01);
        @(posedge core_clk);
        #1;
        chk({15'h0000, out_oe}, 16'h0001);
        $display("test enable and clock done");
    endtask
    task automatic t_pattern();
        adcocr_host_i.wr(8'h19, 8'hcd);
        adcocr_host_i.wr(8'h1a, 8'hab);
        @(posedge core_clk);
        test_sel <= 1'b1;
        @(posedge core_clk);
        test_sel <= 1'b0;
        #1;
        chk({1'b0, out_valid, out_data}, {2'b01, 14'h2af3});
        $display("test pattern done");
    endtask
    task automatic t_self();
        adcocr_host_i.wr(8'h0e, 8'h05);
        repeat (3) @(posedge core_clk);
        #1;
        chk({15'h0000, self_check_run}, 16'h0001);
        adcocr_host_i.wr(8'h0e, 8'h01);
        repeat (3) @(posedge core_clk);
        chk(16'(pulses), 16'h0001);
        $display("test self check done");
    endtask

    task automatic t_analog();
        adcocr_host_i.wr(8'h15, 8'hfa);
        adcocr_host_i.wr(8'h18, 8'hff);
        adcocr_host_i.wr(8'h11, 8'h5a);
        @(posedge core_clk);
        #1;
        chk({7'h00, drive_strength, range_select}, 16'h015f);
        rchk(8'h15, 8'h0a);
        rchk(8'h18, 8'h1f);
        rchk(8'h11, 8'h00);
        $display("test analog settings done");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_offset();
        t_format();
        t_oe_clk();
        t_pattern();
        t_self();
        t_analog();
        summarize();
    end
    // all scenarios need well under 300 cycles
    initial begin
        #(3000 * 100);
        mismatches++;
        summarize();
    end
endmodule // adcocr_regs_tb
